// file: pkg/bcv_pkg.sv
// shared constants and types for the bcd convert / decode / encode datapath
package bcv_pkg;

  // operations issued over the link
  typedef enum logic [2:0] {
    BCV_OP_NONE          = 3'h0,
    INTEGER_TO_BCD_OP    = 3'h1,
    BCD_TO_INTEGER_OP    = 3'h2,
    DECODE_4_TO_16_OP    = 3'h3,
    ENCODE_16_TO_4_OP    = 3'h4,
    BCV_OP_MATH_LOAD     = 3'h5,
    BCV_OP_CLR_MINOR     = 3'h6
  } bcv_op_t;

  // numeric limits
  localparam logic [19:0] BCV_BCD_WORD_MAX   = 20'h09999;
  localparam logic [31:0] BCV_INT_MAX        = 32'h00007FFF;
  localparam int          BCV_DIGITS_WIDE    = 8;
  localparam logic [3:0]  BCV_DIGIT_MAX      = 4'h9;

  // register byte offsets of the controller
  localparam logic [7:0]  BCV_CMD_OFS        = 8'h00;
  localparam logic [7:0]  BCV_SRC_OFS        = 8'h04;
  localparam logic [7:0]  BCV_SRC_HI_OFS     = 8'h08;
  localparam logic [7:0]  BCV_RESULT_OFS     = 8'h0C;
  localparam logic [7:0]  BCV_FLAGS_OFS      = 8'h10;
  localparam logic [7:0]  BCV_MATH_OFS       = 8'h14;
  localparam logic [7:0]  BCV_INT_STAT_OFS   = 8'h18;
  localparam logic [7:0]  BCV_INT_MASK_OFS   = 8'h1C;

  // command register fields
  localparam int          BCV_CMD_OP_LSB     = 0;
  localparam int          BCV_CMD_MATH_BIT   = 4;
  localparam int          BCV_CMD_GO_BIT     = 8;

  // flags register bit positions
  localparam int          BCV_FLG_CARRY      = 0;
  localparam int          BCV_FLG_OVF        = 1;
  localparam int          BCV_FLG_ZERO       = 2;
  localparam int          BCV_FLG_SIGN       = 3;
  localparam int          BCV_FLG_MINOR      = 4;

  // interrupt status bits
  localparam int          BCV_INT_DONE       = 0;
  localparam int          BCV_INT_OVF        = 1;
  localparam int          BCV_INT_MINOR      = 2;
  localparam int          BCV_INT_W          = 3;

  // reset values
  localparam logic [31:0] BCV_MATH_RST       = 32'h00000000;
  localparam logic [15:0] BCV_WORD_RST       = 16'h0000;
  localparam logic [2:0]  BCV_INT_MASK_RST   = 3'h0;

endpackage

// file: pkg/bcv_link_if.sv
// link between the issuing controller and the datapath
`timescale 1ns/1ps
`default_nettype none
interface bcv_link_if;
  import bcv_pkg::*;
  logic        exec;
  bcv_op_t     op;
  logic        math_sel;
  logic [15:0] src_word;
  logic [15:0] src_hi;
  logic        done;
  logic        result_wr;
  logic [15:0] result;
  logic        carry;
  logic        ovf;
  logic        zero;
  logic        sign;
  logic        minor;
  logic [31:0] math;

  modport dev (input exec, op, math_sel, src_word, src_hi,
               output done, result_wr, result, carry, ovf, zero, sign, minor, math);
  modport host (output exec, op, math_sel, src_word, src_hi,
                input done, result_wr, result, carry, ovf, zero, sign, minor, math);
endinterface
`default_nettype wire

// file: rtl/bcv_device.sv
// datapath end: bcd conversions, 4-to-16 decode, 16-to-4 encode, flags and math register
`timescale 1ns/1ps
`default_nettype none
module bcv_device
  import bcv_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  bcv_link_if.dev          link,
  output logic [31:0]      MATH_REG,
  output logic [4:0]       STATUS_FLAGS
);

  typedef struct packed {
    logic        done;
    logic        result_wr;
    logic [15:0] result;
    logic [31:0] math;
    logic        carry;
    logic        ovf;
    logic        zero;
    logic        sign;
    logic        minor;
  } bcv_dev_state_t;

  bcv_dev_state_t q;
  bcv_dev_state_t d;

  // binary magnitude to five bcd digits, shift-and-add-three
  function automatic logic [19:0] bcv_bin_to_bcd(input logic [16:0] bin);
    logic [19:0] bcd;
    bcd = 20'h00000;
    for (int i = 16; i >= 0; i--)
    begin
      for (int k = 0; k < 5; k++)
      begin
        if (bcd[k*4 +: 4] >= 4'h5)
        begin
          bcd[k*4 +: 4] = bcd[k*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[18:0], bin[i]};
    end
    return bcd;
  endfunction

  // true when every nibble is a decimal digit
  function automatic logic bcv_bcd_ok(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < BCV_DIGITS_WIDE; k++)
    begin
      if (v[k*4 +: 4] > BCV_DIGIT_MAX)
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // eight bcd digits to binary, most significant digit first
  function automatic logic [31:0] bcv_bcd_to_bin(input logic [31:0] v);
    logic [31:0] acc;
    acc = 32'h00000000;
    for (int k = BCV_DIGITS_WIDE - 1; k >= 0; k--)
    begin
      acc = (acc << 3) + (acc << 1) + {28'h0000000, v[k*4 +: 4]};
    end
    return acc;
  endfunction

  // index of the lowest set bit, zero when none
  function automatic logic [3:0] bcv_lowest(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  logic [16:0] tod_mag;
  logic [19:0] tod_bcd;
  logic        tod_big;
  logic [31:0] frd_src;
  logic [31:0] frd_val;
  logic        frd_bad;

  // sign dropped: the magnitude is converted
  assign tod_mag = link.src_word[15] ? 17'({1'b0, ~link.src_word} + 17'h00001) : {1'b0, link.src_word};
  assign tod_bcd = bcv_bin_to_bcd(tod_mag);
  assign tod_big = (tod_bcd > BCV_BCD_WORD_MAX);
  // wide source taken as one value, low word low digits
  assign frd_src = link.math_sel ? q.math : {16'h0000, link.src_word};
  assign frd_val = bcv_bcd_to_bin(frd_src);
  assign frd_bad = !bcv_bcd_ok(frd_src) || (frd_val > BCV_INT_MAX);

  always_comb
  begin
    d           = q;
    d.done      = 1'b0;
    d.result_wr = 1'b0;
    // nothing changes without a strobe
    if (link.exec)
    begin
      d.done = 1'b1;
      case (link.op)
        INTEGER_TO_BCD_OP:
        begin
          d.carry = 1'b0;
          d.sign  = link.src_word[15];
          d.ovf   = tod_big;
          if (tod_big)
          begin
            d.minor = 1'b1;
          end
          if (link.math_sel)
          begin
            // full five digits kept even on overflow
            d.math = {12'h000, tod_bcd};
            d.zero = (tod_bcd == 20'h00000);
          end
          else
          begin
            d.result    = tod_bcd[15:0];
            d.result_wr = 1'b1;
            d.zero      = (tod_bcd[15:0] == 16'h0000);
          end
        end
        BCD_TO_INTEGER_OP:
        begin
          // result always goes to a word
          d.result    = frd_val[15:0];
          d.result_wr = 1'b1;
          d.carry     = 1'b0;
          d.sign      = 1'b0;
          d.zero      = (frd_val[15:0] == 16'h0000);
          d.ovf       = frd_bad;
          if (frd_bad)
          begin
            d.minor = 1'b1;
          end
        end
        DECODE_4_TO_16_OP:
        begin
          // only the low nibble selects; flags left alone
          d.result    = 16'h0001 << link.src_word[3:0];
          d.result_wr = 1'b1;
        end
        ENCODE_16_TO_4_OP:
        begin
          // upper destination bits cleared on every write
          d.result    = {12'h000, bcv_lowest(link.src_word)};
          d.result_wr = 1'b1;
          d.zero      = (link.src_word == 16'h0000);
          // minor error bit is left untouched
          d.ovf       = ((link.src_word & (link.src_word - 16'h0001)) != 16'h0000);
          d.carry     = 1'b0;
          d.sign      = 1'b0;
        end
        BCV_OP_MATH_LOAD:
        begin
          // lets the issuer stage a wide source or zero the high word
          d.math = {link.src_hi, link.src_word};
        end
        BCV_OP_CLR_MINOR:
        begin
          d.minor = 1'b0;
        end
        default:
        begin
          d.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      q.done      <= 1'b0;
      q.result_wr <= 1'b0;
      q.result    <= BCV_WORD_RST;
      q.math      <= BCV_MATH_RST;
      q.carry     <= 1'b0;
      q.ovf       <= 1'b0;
      q.zero      <= 1'b0;
      q.sign      <= 1'b0;
      q.minor     <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.done      = q.done;
  assign link.result_wr = q.result_wr;
  assign link.result    = q.result;
  assign link.carry     = q.carry;
  assign link.ovf       = q.ovf;
  assign link.zero      = q.zero;
  assign link.sign      = q.sign;
  assign link.minor     = q.minor;
  assign link.math      = q.math;
  assign MATH_REG       = q.math;
  assign STATUS_FLAGS   = {q.minor, q.sign, q.zero, q.ovf, q.carry};

endmodule
`default_nettype wire

// file: rtl/bcv_host.sv
// issuing end: ahb-lite register slave that sends operations over the link and raises an interrupt
`timescale 1ns/1ps
`default_nettype none
module bcv_host
  import bcv_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             IRQ,
  bcv_link_if.host         link
);

  typedef struct packed {
    logic                 exec;
    bcv_op_t              op;
    logic                 math_sel;
    logic [15:0]          src_word;
    logic [15:0]          src_hi;
    logic [15:0]          result;
    logic [BCV_INT_W-1:0] int_stat;
    logic [BCV_INT_W-1:0] int_mask;
    logic                 minor_seen;
    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [31:0]          rdata;
    logic                 irq;
  } bcv_host_state_t;

  bcv_host_state_t q;
  bcv_host_state_t d;

  logic                 acc;
  logic [7:0]           ofs;
  logic [BCV_INT_W-1:0] set;
  logic [BCV_INT_W-1:0] clr;
  logic [31:0]          rd_mux;

  assign acc = HSEL && HTRANS[1] && HREADY;
  assign ofs = HADDR[7:0];

  always_comb
  begin
    if (ofs == BCV_CMD_OFS)
      rd_mux = {24'h000000, 3'h0, q.math_sel, 1'b0, q.op};
    else if (ofs == BCV_SRC_OFS)
      rd_mux = {16'h0000, q.src_word};
    else if (ofs == BCV_SRC_HI_OFS)
      rd_mux = {16'h0000, q.src_hi};
    else if (ofs == BCV_RESULT_OFS)
      rd_mux = {16'h0000, q.result};
    else if (ofs == BCV_FLAGS_OFS)
      rd_mux = {27'h0000000, link.minor, link.sign, link.zero, link.ovf, link.carry};
    else if (ofs == BCV_MATH_OFS)
      rd_mux = link.math;
    else if (ofs == BCV_INT_STAT_OFS)
      rd_mux = {29'h00000000, q.int_stat};
    else if (ofs == BCV_INT_MASK_OFS)
      rd_mux = {29'h00000000, q.int_mask};
    else
      rd_mux = 32'h00000000;
  end

  always_comb
  begin
    d            = q;
    d.exec       = 1'b0;
    set          = '0;
    clr          = '0;
    d.minor_seen = link.minor;
    set[BCV_INT_DONE]  = link.done;
    set[BCV_INT_OVF]   = link.done && link.ovf;
    set[BCV_INT_MINOR] = link.minor && !q.minor_seen;
    if (link.result_wr)
    begin
      d.result = link.result;
    end
    // write data phase
    if (q.wr_pend)
    begin
      if (q.wr_addr == BCV_CMD_OFS)
      begin
        d.op       = bcv_op_t'(HWDATA[BCV_CMD_OP_LSB +: 3]);
        d.math_sel = HWDATA[BCV_CMD_MATH_BIT];
        // one strobe per go write
        d.exec     = HWDATA[BCV_CMD_GO_BIT];
      end
      else if (q.wr_addr == BCV_SRC_OFS)
        d.src_word = HWDATA[15:0];
      else if (q.wr_addr == BCV_SRC_HI_OFS)
        d.src_hi = HWDATA[15:0];
      else if (q.wr_addr == BCV_INT_STAT_OFS)
        clr = HWDATA[BCV_INT_W-1:0];
      else if (q.wr_addr == BCV_INT_MASK_OFS)
        d.int_mask = HWDATA[BCV_INT_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    d.int_stat = (q.int_stat & ~clr) | set;
    d.irq      = |(d.int_stat & d.int_mask);
    d.wr_pend  = acc && HWRITE;
    if (acc)
    begin
      d.wr_addr = ofs;
      if (!HWRITE)
      begin
        d.rdata = rd_mux;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      q.exec       <= 1'b0;
      q.op         <= BCV_OP_NONE;
      q.math_sel   <= 1'b0;
      q.src_word   <= BCV_WORD_RST;
      q.src_hi     <= BCV_WORD_RST;
      q.result     <= BCV_WORD_RST;
      q.int_stat   <= '0;
      q.int_mask   <= BCV_INT_MASK_RST;
      q.minor_seen <= 1'b0;
      q.wr_pend    <= 1'b0;
      q.wr_addr    <= 8'h00;
      q.rdata      <= 32'h00000000;
      q.irq        <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.exec     = q.exec;
  assign link.op       = q.op;
  assign link.math_sel = q.math_sel;
  assign link.src_word = q.src_word;
  assign link.src_hi   = q.src_hi;
  assign HRDATA        = q.rdata;
  assign HREADYOUT     = RESET_N;
  assign HRESP         = 1'b0;
  assign IRQ           = q.irq;

endmodule
`default_nettype wire

// file: dv/bcv_link_assertions.sv
// link checker for the bcd datapath
`timescale 1ns/1ps
`default_nettype none
module bcv_link_assertions
  import bcv_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        exec,
  input wire bcv_op_t     op,
  input wire logic [15:0] src_word,
  input wire logic        done,
  input wire logic        result_wr,
  input wire logic [15:0] result,
  input wire logic        carry,
  input wire logic        ovf,
  input wire logic        zero,
  input wire logic        sign,
  input wire logic        minor,
  input wire logic [31:0] math
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_go(bcv_op_t o);
    exec && op == o;
  endsequence
  a_one_done: assert property (exec && op != BCV_OP_NONE && op != bcv_op_t'(3'h7) |=> done)
    else $error("no done after exec");
  a_idle_hold: assert property (!exec |=> !done && $stable({result, carry, ovf, zero, sign, minor, math}))
    else $error("change without exec");
  a_dec_onehot: assert property (s_go(DECODE_4_TO_16_OP) |=> result_wr && result == 16'h1 << $past(src_word[3:0]))
    else $error("decode word wrong");
  a_dec_flags: assert property (s_go(DECODE_4_TO_16_OP) |=> $stable({carry, ovf, zero, sign, minor}))
    else $error("decode touched flags");
  a_enc_clear: assert property (s_go(ENCODE_16_TO_4_OP) |=> result[15:4] == 12'h0 && !carry && !sign)
    else $error("encode high bits or flags");
  a_enc_ovf: assert property (s_go(ENCODE_16_TO_4_OP) |=> ovf == ($countones($past(src_word)) > 1))
    else $error("encode overflow wrong");
  a_enc_zero: assert property (s_go(ENCODE_16_TO_4_OP) ##0 src_word == 16'h0 |=> zero && result == 16'h0)
    else $error("encode zero source");
  a_enc_lowest: assert property (s_go(ENCODE_16_TO_4_OP) ##0 src_word != 16'h0 |=>
    (($past(src_word) >> result[3:0]) & 16'h1) == 16'h1 &&
    ($past(src_word) & ((16'h1 << result[3:0]) - 16'h1)) == 16'h0)
    else $error("encode index wrong");
  a_frd_flags: assert property (s_go(BCD_TO_INTEGER_OP) |=> result_wr && !carry && !sign && zero == (result == 16'h0))
    else $error("bcd to int flags");
  a_ovf_minor: assert property ((s_go(INTEGER_TO_BCD_OP) or s_go(BCD_TO_INTEGER_OP)) ##1 ovf |-> minor)
    else $error("overflow without minor");
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// testbench: ahb master driving the issuing end joined to the datapath
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bcv_pkg::*;
;
  logic        CLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, e_irq;
  logic [31:0] HADDR, HWDATA, HRDATA, MATH_REG, seed, rd, e_math;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [4:0]  STATUS_FLAGS, e_flg;
  logic [15:0] e_res;
  int          n_mismatch, n_checks;
  bcv_link_if link ();
  bcv_host bcv_host_inst (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .link(link));
  bcv_device bcv_device_inst (.CLK(CLK), .RESET_N(RESET_N), .link(link), .MATH_REG(MATH_REG),
    .STATUS_FLAGS(STATUS_FLAGS));
  bcv_link_assertions bcv_link_assertions_inst (.CLK(CLK), .RESET_N(RESET_N), .exec(link.exec), .op(link.op),
    .src_word(link.src_word), .done(link.done), .result_wr(link.result_wr), .result(link.result),
    .carry(link.carry), .ovf(link.ovf), .zero(link.zero), .sign(link.sign), .minor(link.minor), .math(link.math));
  initial
  begin
    CLK = 1'h0;
    forever #20 CLK = ~CLK;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [19:0] to_bcd(input logic [16:0] m);
    logic [19:0] b;
    for (int i = 0; i < 5; i++)
    begin
      b[4*i+:4] = 4'(m % 17'hA);
      m = m / 17'hA;
    end
    return b;
  endfunction
  // {bad digit, value} of eight digits
  function automatic logic [32:0] from_bcd(input logic [31:0] v);
    logic [31:0] r;
    logic        bad;
    r = 32'h0;
    bad = 1'h0;
    for (int i = 7; i >= 0; i--)
    begin
      r = r * 32'hA + {28'h0, v[4*i+:4]};
      bad |= v[4*i+:4] > 4'h9;
    end
    return {bad, r};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wt;
    int k;
    k = 0;
    do
    begin
      @(posedge CLK);
      k++;
    end
    while (HREADYOUT !== 1'h1 && k < 50);
    if (k >= 50)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'h1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    wt();
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wt();
    rd = HRDATA;
  endtask
  task automatic run(input bcv_op_t op, input logic s, input logic [15:0] src, input logic [15:0] hi);
    logic [32:0] f;
    logic [19:0] b;
    logic [4:0]  fm;
    logic [15:0] mk;
    int          k;
    mk = 16'hFFFF;
    case (op)
      INTEGER_TO_BCD_OP:
      begin
        b = to_bcd(src[15] ? 17'h10000 - {1'h0, src} : {1'h0, src});
        e_flg[3:0] = {src[15], s ? b == 20'h0 : b[15:0] == 16'h0, b > BCV_BCD_WORD_MAX, 1'h0};
        e_flg[4] |= b > BCV_BCD_WORD_MAX;
        if (s)
          e_math = {12'h0, b};
        else
          e_res = b[15:0];
      end
      BCD_TO_INTEGER_OP:
      begin
        f = from_bcd(s ? e_math : {16'h0, src});
        e_res = f[15:0];
        mk = f[32] ? 16'h0 : 16'hFFFF;
        e_flg[3:0] = {1'h0, e_res == 16'h0, f[32] || f[31:0] > BCV_INT_MAX, 1'h0};
        e_flg[4] |= e_flg[1];
      end
      DECODE_4_TO_16_OP: e_res = 16'h1 << src[3:0];
      ENCODE_16_TO_4_OP:
      begin
        e_res = 16'h0;
        for (k = 15; k >= 0; k--)
          if (src[k])
            e_res = k[15:0];
        e_flg[3:0] = {1'h0, src == 16'h0, $countones(src) > 1, 1'h0};
      end
      BCV_OP_MATH_LOAD: e_math = {hi, src};
      BCV_OP_CLR_MINOR: e_flg[4] = 1'h0;
      default: ;
    endcase
    fm = {2'h3, mk[0], 2'h3};
    ahb(1'h1, BCV_SRC_OFS, {16'h0, src});
    // source word must read back unchanged before it is converted
    ahb(1'h0, BCV_SRC_OFS, 32'h0);
    chk(rd, {16'h0, src});
    ahb(1'h1, BCV_SRC_HI_OFS, {16'h0, hi});
    ahb(1'h1, BCV_CMD_OFS, {23'h0, 1'h1, 3'h0, s, 1'h0, op});
    k = 0;
    do
    begin
      ahb(1'h0, BCV_INT_STAT_OFS, 32'h0);
      k++;
    end
    while (rd[0] !== 1'h1 && k < 20);
    chk({31'h0, rd[0]}, 32'h1);
    if (rd[0] !== 1'h1)
      summarize();
    chk({31'h0, rd[1]}, {31'h0, e_flg[1]});
    ahb(1'h0, BCV_RESULT_OFS, 32'h0);
    chk(rd & {16'h0, mk}, {16'h0, e_res & mk});
    ahb(1'h0, BCV_FLAGS_OFS, 32'h0);
    chk(rd & {27'h0, fm}, {27'h0, e_flg & fm});
    chk({27'h0, STATUS_FLAGS & fm}, {27'h0, e_flg & fm});
    ahb(1'h0, BCV_MATH_OFS, 32'h0);
    chk(rd, e_math);
    chk(MATH_REG, e_math);
    chk({31'h0, IRQ}, {31'h0, e_irq});
    ahb(1'h1, BCV_INT_STAT_OFS, 32'h7);
  endtask
  initial
  begin
    repeat (100000) @(posedge CLK);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {HSEL, HWRITE, HADDR, HWDATA, HTRANS, RESET_N, e_irq, e_res, e_math, e_flg} = '0;
    HSIZE = 3'h2;
    n_mismatch = 0;
    n_checks = 0;
    seed = 32'h0000ABA4;
    repeat (16) @(posedge CLK);
    RESET_N <= 1'h1;
    @(posedge CLK);
    for (int i = 0; i < 9; i++)
    begin
      ahb(1'h0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, HRESP}, 32'h0);
    end
    ahb(1'h1, 8'h24, 32'hFFFFFFFF);
    ahb(1'h0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    ahb(1'h1, BCV_INT_MASK_OFS, 32'h1);
    e_irq = 1'h1;
    run(INTEGER_TO_BCD_OP, 1'h0, 16'h270F, 16'h0);
    run(INTEGER_TO_BCD_OP, 1'h1, 16'h3039, 16'h0);
    run(INTEGER_TO_BCD_OP, 1'h0, 16'h8000, 16'h0);
    run(BCV_OP_CLR_MINOR, 1'h0, 16'h0, 16'h0);
    run(BCD_TO_INTEGER_OP, 1'h1, 16'h0, 16'h0);
    run(BCV_OP_MATH_LOAD, 1'h0, 16'h2760, 16'h0003);
    run(BCD_TO_INTEGER_OP, 1'h1, 16'h0, 16'h0);
    run(BCV_OP_MATH_LOAD, 1'h0, 16'h2768, 16'h0003);
    run(BCD_TO_INTEGER_OP, 1'h1, 16'h0, 16'h0);
    run(BCV_OP_MATH_LOAD, 1'h0, 16'h1234, 16'h0099);
    run(BCD_TO_INTEGER_OP, 1'h1, 16'h0, 16'h0);
    run(BCV_OP_MATH_LOAD, 1'h0, 16'h1234, 16'h0000);
    run(BCD_TO_INTEGER_OP, 1'h1, 16'h0, 16'h0);
    run(BCD_TO_INTEGER_OP, 1'h0, 16'h00A1, 16'h0);
    run(BCD_TO_INTEGER_OP, 1'h0, 16'h0, 16'h0);
    run(ENCODE_16_TO_4_OP, 1'h0, 16'h0, 16'h0);
    run(ENCODE_16_TO_4_OP, 1'h0, 16'h0014, 16'h0);
    repeat (2) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    ahb(1'h1, BCV_INT_MASK_OFS, 32'h0);
    e_irq = 1'h0;
    $display("test corners done");
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      run(DECODE_4_TO_16_OP, 1'h0, {seed[15:4], 4'(i)}, 16'h0);
      run(ENCODE_16_TO_4_OP, 1'h0, (seed[15:0] << i) | (16'h1 << i), 16'h0);
    end
    for (int i = 0; i < 60; i++)
    begin
      seed = xs(seed);
      run(bcv_op_t'({1'h0, seed[1:0]} + 3'h1), seed[2], seed[31:16], seed[15:0]);
    end
    $display("test random done");
    summarize();
  end
endmodule
`default_nettype wire
